// ### src/sfd_regbank.sv
// Register bank and Avalon-MM slave for two supply fault detectors.
// Assumes a master that holds each request until waitrequest is low.
//
// Overview of operation
// [RULE1] Eight-bit high limit code per channel
// [RULE2] High hysteresis lowers limit while flagged
// [RULE3] Eight-bit low limit code per channel
// [RULE4] Low hysteresis raises limit while flagged
// [RULE5] Glitch filter codes select 0 to 100 us
// [RULE6] Fault kind: high, both, low, off
// [RULE7] Channel four range: mid, low, ultralow
// [RULE8] Software ignores unused upper register bits
// [RULE9] High-voltage range is single bit zero
// [RULE10] Flag only after condition outlasts filter delay
`timescale 1ns/10ps
`default_nettype none

module sfd_regbank #(
	parameter int unsigned FILT_30_CYC = sfd_pkg::us_to_cyc(sfd_pkg::GF_US_30),
	parameter int unsigned FILT_50_CYC = sfd_pkg::us_to_cyc(sfd_pkg::GF_US_50),
	parameter int unsigned FILT_75_CYC = sfd_pkg::us_to_cyc(sfd_pkg::GF_US_75),
	parameter int unsigned FILT_100_CYC =
		sfd_pkg::us_to_cyc(sfd_pkg::GF_US_100)
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [sfd_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [sfd_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [sfd_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [sfd_pkg::LIMIT_W-1:0] ch4Level,
	input wire logic [sfd_pkg::LIMIT_W-1:0] hvLevel,
	output logic ch4HighFlag,
	output logic ch4LowFlag,
	output logic hvHighFlag,
	output logic hvLowFlag,
	output logic [sfd_pkg::RANGE_W-1:0] ch4RangeSel,
	output logic hvRangeSel,
	output logic irq
);
	import sfd_pkg::*;

	localparam logic [CNT_W-1:0] D5 = CNT_W'(FILT_5_CYC);
	localparam logic [CNT_W-1:0] D10 = CNT_W'(FILT_10_CYC);
	localparam logic [CNT_W-1:0] D20 = CNT_W'(FILT_20_CYC);
	localparam logic [CNT_W-1:0] D30 = CNT_W'(FILT_30_CYC);
	localparam logic [CNT_W-1:0] D50 = CNT_W'(FILT_50_CYC);
	localparam logic [CNT_W-1:0] D75 = CNT_W'(FILT_75_CYC);
	localparam logic [CNT_W-1:0] D100 = CNT_W'(FILT_100_CYC);

	// Stored configuration fields
	logic [LIMIT_W-1:0] ch4HighLim_ff;
	logic [HYST_W-1:0] ch4HighHyst_ff;
	logic [LIMIT_W-1:0] ch4LowLim_ff;
	logic [HYST_W-1:0] ch4LowHyst_ff;
	logic [GF_W-1:0] ch4Gf_ff;
	logic [KIND_W-1:0] ch4Kind_ff;
	logic [RANGE_W-1:0] ch4Sel_ff;
	logic [LIMIT_W-1:0] hvHighLim_ff;
	logic [HYST_W-1:0] hvHighHyst_ff;
	logic [LIMIT_W-1:0] hvLowLim_ff;
	logic [HYST_W-1:0] hvLowHyst_ff;
	logic [GF_W-1:0] hvGf_ff;
	logic [KIND_W-1:0] hvKind_ff;
	logic hvSel_ff;

	// Output and interrupt state
	logic [RANGE_W-1:0] ch4Range_ff;
	logic hvRange_ff;
	logic [EV_W-1:0] status_ff;
	logic [EV_W-1:0] mask_ff;
	logic [EV_W-1:0] prevFlags_ff;
	logic irq_ff;

	// Bus state
	sfd_bus_t bus_ff;
	logic waitReq_ff;
	logic [DATA_W-1:0] rdData_ff;

	logic [EV_W-1:0] liveFlags;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] clrBits;
	logic [EV_W-1:0] nxt_status;
	logic [IDX_W-1:0] regIdx;
	logic aligned;
	logic request;
	logic accept;
	logic commit;
	logic wrCommit;
	logic rdCommit;
	logic [7:0] wrByte;
	logic [DATA_W-1:0] rdMux;
	logic [RANGE_W-1:0] ch4RangeNorm;
	sfd_bus_t nxt_bus;

	// Detector channel for the fourth positive supply
	sfd_channel #(
		.DLY5(D5), .DLY10(D10), .DLY20(D20), .DLY30(D30),
		.DLY50(D50), .DLY75(D75), .DLY100(D100)
	) u_ch4 (
		.clock(clock),
		.rst(rst),
		.level(ch4Level),
		.highLimit(ch4HighLim_ff),
		.highHyst(ch4HighHyst_ff),
		.lowLimit(ch4LowLim_ff),
		.lowHyst(ch4LowHyst_ff),
		.glitchSel(ch4Gf_ff),
		.faultKind(ch4Kind_ff),
		.highFlag(liveFlags[EV_CH4_HIGH]),
		.lowFlag(liveFlags[EV_CH4_LOW])
	);

	// Detector channel for the high-voltage supply
	sfd_channel #(
		.DLY5(D5), .DLY10(D10), .DLY20(D20), .DLY30(D30),
		.DLY50(D50), .DLY75(D75), .DLY100(D100)
	) u_hv (
		.clock(clock),
		.rst(rst),
		.level(hvLevel),
		.highLimit(hvHighLim_ff),
		.highHyst(hvHighHyst_ff),
		.lowLimit(hvLowLim_ff),
		.lowHyst(hvLowHyst_ff),
		.glitchSel(hvGf_ff),
		.faultKind(hvKind_ff),
		.highFlag(liveFlags[EV_HV_HIGH]),
		.lowFlag(liveFlags[EV_HV_LOW])
	);

	// Word map, byte address is four times the index, data in [7:0]:
	//   0x18 channel four high limit
	//   0x19 channel four high hysteresis, bits [4:0]
	//   0x1A channel four low limit
	//   0x1B channel four low hysteresis, bits [4:0]
	//   0x1C channel four filter [4:2] and fault kind [1:0]
	//   0x1D channel four range code, bits [1:0]
	//   0x20 to 0x25 same layout for the high-voltage channel,
	//   except that its range register keeps only bit 0
	//   0x30 sticky event status, cleared by reading it
	//   0x31 event mask, same layout as the status
	//   0x32 live filtered flags, read only
	// Event bits: 0 ch4 high, 1 ch4 low, 2 hv high, 3 hv low.
	//
	// Things a user of this bank should know:
	//   every access costs one wait cycle, reads and writes alike;
	//   a status read clears only the bits it returned, so an event
	//   landing between take and answer waits for the next read;
	//   the interrupt follows the status one cycle late;
	//   range code 3 reads back as 3 but drives the ultralow code;
	//   the filters restart whenever a limit write drops the condition.

	// Address decode and handshake qualifiers
	assign regIdx = avs_address[ADDR_W-1:IDX_LSB];
	assign aligned = avs_address[IDX_LSB-1:0] == WORD_ALIGN;
	assign request = avs_read | avs_write;
	assign accept = request & (bus_ff == BUS_IDLE);
	assign commit = request & (bus_ff == BUS_ANSWER);
	assign wrCommit = commit & avs_write & aligned & avs_byteenable[0];
	assign rdCommit = commit & avs_read & aligned;
	assign wrByte = avs_writedata[7:0];
	assign nxt_bus = accept ? BUS_ANSWER : BUS_IDLE;

	// Codes 2 and 3 both select the ultralow range
	assign ch4RangeNorm = (wrByte[RANGE_W-1:0] == RANGE_ULTRA_ALT) ?
		RANGE_ULTRA : wrByte[RANGE_W-1:0]; // [RULE7]

	// Read mux; unused upper bits read as zero, unmapped reads as zero
	assign rdMux = !aligned ? '0 :
		(regIdx == IDX_CH4_HIGH_LIMIT) ? DATA_W'(ch4HighLim_ff) :
		(regIdx == IDX_CH4_HIGH_HYST) ? DATA_W'(ch4HighHyst_ff) :
		(regIdx == IDX_CH4_LOW_LIMIT) ? DATA_W'(ch4LowLim_ff) :
		(regIdx == IDX_CH4_LOW_HYST) ? DATA_W'(ch4LowHyst_ff) :
		(regIdx == IDX_CH4_FILT_TYPE) ? DATA_W'({ch4Gf_ff, ch4Kind_ff}) :
		(regIdx == IDX_CH4_RANGE) ? DATA_W'(ch4Sel_ff) :
		(regIdx == IDX_HV_HIGH_LIMIT) ? DATA_W'(hvHighLim_ff) :
		(regIdx == IDX_HV_HIGH_HYST) ? DATA_W'(hvHighHyst_ff) :
		(regIdx == IDX_HV_LOW_LIMIT) ? DATA_W'(hvLowLim_ff) :
		(regIdx == IDX_HV_LOW_HYST) ? DATA_W'(hvLowHyst_ff) :
		(regIdx == IDX_HV_FILT_TYPE) ? DATA_W'({hvGf_ff, hvKind_ff}) :
		(regIdx == IDX_HV_RANGE) ? DATA_W'(hvSel_ff) : // [RULE9]
		(regIdx == IDX_IRQ_STATUS) ? DATA_W'(status_ff) :
		(regIdx == IDX_IRQ_MASK) ? DATA_W'(mask_ff) :
		(regIdx == IDX_LIVE_FLAGS) ? DATA_W'(prevFlags_ff) : '0;

	// Rising flags are events; a status read clears only the bits it saw
	assign events = liveFlags & ~prevFlags_ff;
	assign clrBits = (rdCommit & (regIdx == IDX_IRQ_STATUS)) ?
		rdData_ff[EV_W-1:0] : RST_EV;
	assign nxt_status = (status_ff & ~clrBits) | events;

	// One wait cycle per access: data loads on take, commits on answer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus_ff <= BUS_IDLE;
			waitReq_ff <= 1'b1;
			rdData_ff <= '0;
		end else begin
			bus_ff <= nxt_bus;
			waitReq_ff <= ~accept;
			if (accept & avs_read) begin
				rdData_ff <= rdMux;
			end
		end
	end

	// Channel four configuration writes keep only the meaningful fields
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ch4HighLim_ff <= RST_HIGH_LIMIT;
			ch4HighHyst_ff <= RST_HYST;
			ch4LowLim_ff <= RST_LOW_LIMIT;
			ch4LowHyst_ff <= RST_HYST;
			ch4Gf_ff <= RST_GF;
			ch4Kind_ff <= RST_KIND;
			ch4Sel_ff <= RST_RANGE;
			ch4Range_ff <= RST_RANGE;
		end else if (wrCommit) begin
			case (regIdx)
				IDX_CH4_HIGH_LIMIT: ch4HighLim_ff <= wrByte; // [RULE1]
				IDX_CH4_HIGH_HYST: ch4HighHyst_ff <= wrByte[HYST_W-1:0]; // [RULE2]
				IDX_CH4_LOW_LIMIT: ch4LowLim_ff <= wrByte; // [RULE3]
				IDX_CH4_LOW_HYST: ch4LowHyst_ff <= wrByte[HYST_W-1:0]; // [RULE4]
				IDX_CH4_FILT_TYPE: begin
					ch4Gf_ff <= wrByte[GF_MSB:GF_LSB]; // [RULE5]
					ch4Kind_ff <= wrByte[KIND_MSB:KIND_LSB]; // [RULE6]
				end
				IDX_CH4_RANGE: begin
					ch4Sel_ff <= wrByte[RANGE_W-1:0];
					ch4Range_ff <= ch4RangeNorm; // [RULE7]
				end
				default: begin
				end
			endcase
		end
	end

	// High-voltage channel configuration writes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hvHighLim_ff <= RST_HIGH_LIMIT;
			hvHighHyst_ff <= RST_HYST;
			hvLowLim_ff <= RST_LOW_LIMIT;
			hvLowHyst_ff <= RST_HYST;
			hvGf_ff <= RST_GF;
			hvKind_ff <= RST_KIND;
			hvSel_ff <= 1'b0;
			hvRange_ff <= 1'b0;
		end else if (wrCommit) begin
			case (regIdx)
				IDX_HV_HIGH_LIMIT: hvHighLim_ff <= wrByte; // [RULE1]
				IDX_HV_HIGH_HYST: hvHighHyst_ff <= wrByte[HYST_W-1:0]; // [RULE2]
				IDX_HV_LOW_LIMIT: hvLowLim_ff <= wrByte; // [RULE3]
				IDX_HV_LOW_HYST: hvLowHyst_ff <= wrByte[HYST_W-1:0]; // [RULE4]
				IDX_HV_FILT_TYPE: begin
					hvGf_ff <= wrByte[GF_MSB:GF_LSB]; // [RULE5]
					hvKind_ff <= wrByte[KIND_MSB:KIND_LSB]; // [RULE6]
				end
				IDX_HV_RANGE: begin
					hvSel_ff <= wrByte[HV_RANGE_BIT]; // [RULE9]
					hvRange_ff <= wrByte[HV_RANGE_BIT]; // [RULE9]
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky status, mask and interrupt level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			status_ff <= RST_EV;
			mask_ff <= RST_EV;
			prevFlags_ff <= RST_EV;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			prevFlags_ff <= liveFlags;
			irq_ff <= |(status_ff & mask_ff);
			if (wrCommit & (regIdx == IDX_IRQ_MASK)) begin
				mask_ff <= wrByte[EV_W-1:0];
			end
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata = rdData_ff;
	assign avs_waitrequest = waitReq_ff;
	assign ch4HighFlag = prevFlags_ff[EV_CH4_HIGH];
	assign ch4LowFlag = prevFlags_ff[EV_CH4_LOW];
	assign hvHighFlag = prevFlags_ff[EV_HV_HIGH];
	assign hvLowFlag = prevFlags_ff[EV_HV_LOW];
	assign ch4RangeSel = ch4Range_ff;
	assign hvRangeSel = hvRange_ff;
	assign irq = irq_ff;

endmodule : sfd_regbank

`default_nettype wire

// ### shared/sfd_pkg.sv
// Shared constants for the supply fault detector register bank.
// Assumes a single 200 MHz clock and a 32-bit Avalon-MM register port.
`default_nettype none

package sfd_pkg;

	// Bus geometry: byte address is four times the register index
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// Register indices
	localparam logic [IDX_W-1:0] IDX_CH4_HIGH_LIMIT = 6'h18;
	localparam logic [IDX_W-1:0] IDX_CH4_HIGH_HYST = 6'h19;
	localparam logic [IDX_W-1:0] IDX_CH4_LOW_LIMIT = 6'h1A;
	localparam logic [IDX_W-1:0] IDX_CH4_LOW_HYST = 6'h1B;
	localparam logic [IDX_W-1:0] IDX_CH4_FILT_TYPE = 6'h1C;
	localparam logic [IDX_W-1:0] IDX_CH4_RANGE = 6'h1D;
	localparam logic [IDX_W-1:0] IDX_HV_HIGH_LIMIT = 6'h20;
	localparam logic [IDX_W-1:0] IDX_HV_HIGH_HYST = 6'h21;
	localparam logic [IDX_W-1:0] IDX_HV_LOW_LIMIT = 6'h22;
	localparam logic [IDX_W-1:0] IDX_HV_LOW_HYST = 6'h23;
	localparam logic [IDX_W-1:0] IDX_HV_FILT_TYPE = 6'h24;
	localparam logic [IDX_W-1:0] IDX_HV_RANGE = 6'h25;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h30;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h31;
	localparam logic [IDX_W-1:0] IDX_LIVE_FLAGS = 6'h32;

	// Field widths and positions
	localparam int LIMIT_W = 8;
	localparam int HYST_W = 5;
	localparam int GF_W = 3;
	localparam int KIND_W = 2;
	localparam int RANGE_W = 2;
	localparam int GF_LSB = 2;
	localparam int GF_MSB = 4;
	localparam int KIND_LSB = 0;
	localparam int KIND_MSB = 1;
	localparam int HV_RANGE_BIT = 0;

	// Fault kind encodings
	typedef enum logic [KIND_W-1:0] {
		KIND_HIGH = 2'h0,
		KIND_BOTH = 2'h1,
		KIND_LOW = 2'h2,
		KIND_OFF = 2'h3
	} sfd_kind_t;

	// Input range encodings; code 3 is folded onto code 2
	localparam logic [RANGE_W-1:0] RANGE_MID = 2'h0;
	localparam logic [RANGE_W-1:0] RANGE_LOW = 2'h1;
	localparam logic [RANGE_W-1:0] RANGE_ULTRA = 2'h2;
	localparam logic [RANGE_W-1:0] RANGE_ULTRA_ALT = 2'h3;

	// Event bit layout of status, mask and live flag registers
	localparam int EV_W = 4;
	localparam int EV_CH4_HIGH = 0;
	localparam int EV_CH4_LOW = 1;
	localparam int EV_HV_HIGH = 2;
	localparam int EV_HV_LOW = 3;

	// Reset values
	localparam logic [LIMIT_W-1:0] RST_HIGH_LIMIT = 8'hFF;
	localparam logic [LIMIT_W-1:0] RST_LOW_LIMIT = 8'h00;
	localparam logic [HYST_W-1:0] RST_HYST = 5'h00;
	localparam logic [GF_W-1:0] RST_GF = 3'h0;
	localparam logic [KIND_W-1:0] RST_KIND = KIND_OFF;
	localparam logic [RANGE_W-1:0] RST_RANGE = RANGE_MID;
	localparam logic [EV_W-1:0] RST_EV = 4'h0;

	// Glitch filter delays in microseconds and the clock rate
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned GF_US_5 = 5;
	localparam int unsigned GF_US_10 = 10;
	localparam int unsigned GF_US_20 = 20;
	localparam int unsigned GF_US_30 = 30;
	localparam int unsigned GF_US_50 = 50;
	localparam int unsigned GF_US_75 = 75;
	localparam int unsigned GF_US_100 = 100;
	localparam int CNT_W = 15;
	localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;

	// Cycles for a delay given in microseconds
	function automatic int unsigned us_to_cyc(input int unsigned us);
		return us * CLK_MHZ;
	endfunction : us_to_cyc

	localparam int unsigned FILT_5_CYC = us_to_cyc(GF_US_5);
	localparam int unsigned FILT_10_CYC = us_to_cyc(GF_US_10);
	localparam int unsigned FILT_20_CYC = us_to_cyc(GF_US_20);

	// Bus handshake phase
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} sfd_bus_t;

endpackage : sfd_pkg

`default_nettype wire

// ### src/sfd_channel.sv
// One supply fault detector channel: hysteretic comparators and filters.
// Assumes the level code is synchronous to clock and updated by the ADC.
`timescale 1ns/10ps
`default_nettype none

module sfd_channel #(
	parameter logic [sfd_pkg::CNT_W-1:0] DLY5 = 15'h03E8,
	parameter logic [sfd_pkg::CNT_W-1:0] DLY10 = 15'h07D0,
	parameter logic [sfd_pkg::CNT_W-1:0] DLY20 = 15'h0FA0,
	parameter logic [sfd_pkg::CNT_W-1:0] DLY30 = 15'h1770,
	parameter logic [sfd_pkg::CNT_W-1:0] DLY50 = 15'h2710,
	parameter logic [sfd_pkg::CNT_W-1:0] DLY75 = 15'h3A98,
	parameter logic [sfd_pkg::CNT_W-1:0] DLY100 = 15'h4E20
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [sfd_pkg::LIMIT_W-1:0] level,
	input wire logic [sfd_pkg::LIMIT_W-1:0] highLimit,
	input wire logic [sfd_pkg::HYST_W-1:0] highHyst,
	input wire logic [sfd_pkg::LIMIT_W-1:0] lowLimit,
	input wire logic [sfd_pkg::HYST_W-1:0] lowHyst,
	input wire logic [sfd_pkg::GF_W-1:0] glitchSel,
	input wire logic [sfd_pkg::KIND_W-1:0] faultKind,
	output logic highFlag,
	output logic lowFlag
);
	import sfd_pkg::*;

	localparam logic [CNT_W-1:0] DLY_TAB [8] = '{
		CNT_ZERO, DLY5, DLY10, DLY20, DLY30, DLY50, DLY75, DLY100
	};

	logic highRaw_ff;
	logic lowRaw_ff;
	logic [LIMIT_W:0] highDiff;
	logic [LIMIT_W-1:0] highEff;
	logic [LIMIT_W:0] lowEff;
	logic highNow;
	logic lowNow;
	logic [CNT_W-1:0] delaySel;
	logic [1:0] cond;
	logic [1:0] flag_ff;

	// Effective high threshold drops by the hysteresis while high is active
	assign highDiff = highRaw_ff ?
		({1'b0, highLimit} - {4'h0, highHyst}) : {1'b0, highLimit}; // [RULE1] [RULE2]
	assign highEff = highDiff[LIMIT_W] ? 8'h00 : highDiff[LIMIT_W-1:0];
	assign highNow = level > highEff; // [RULE1]

	// Effective low threshold rises by its own hysteresis while low is active
	assign lowEff = lowRaw_ff ?
		({1'b0, lowLimit} + {4'h0, lowHyst}) : {1'b0, lowLimit}; // [RULE3] [RULE4]
	assign lowNow = {1'b0, level} < lowEff; // [RULE3]

	// Fault kind gates which comparator may raise a flag
	assign cond[0] = highRaw_ff &
		((faultKind == KIND_HIGH) | (faultKind == KIND_BOTH)); // [RULE6]
	assign cond[1] = lowRaw_ff &
		((faultKind == KIND_LOW) | (faultKind == KIND_BOTH)); // [RULE6]
	assign delaySel = DLY_TAB[glitchSel]; // [RULE5]

	// Raw comparator state feeds back into the hysteresis
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			highRaw_ff <= 1'b0;
			lowRaw_ff <= 1'b0;
		end else begin
			highRaw_ff <= highNow;
			lowRaw_ff <= lowNow;
		end
	end

	// Persistence filters; a drop of the condition restarts the count
	for (genvar i = 0; i < 2; i++) begin : g_filt
		logic [CNT_W-1:0] cnt_ff;
		logic [CNT_W-1:0] nxt_cnt;
		assign nxt_cnt = !cond[i] ? CNT_ZERO :
			(cnt_ff >= delaySel) ? cnt_ff : cnt_ff + CNT_ONE; // [RULE10]
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				cnt_ff <= CNT_ZERO;
				flag_ff[i] <= 1'b0;
			end else begin
				cnt_ff <= nxt_cnt;
				flag_ff[i] <= cond[i] & (cnt_ff >= delaySel); // [RULE10]
			end
		end
	end

	assign highFlag = flag_ff[0];
	assign lowFlag = flag_ff[1];

endmodule : sfd_channel

`default_nettype wire

// ### testbench/sfd_regbank_props.sv
// Checker for the supply fault detector register bank ports.
// Assumes it is bound onto sfd_regbank and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module sfd_regbank_props
	import sfd_pkg::*;
#(
	parameter int unsigned FILT_30_CYC = 6000,
	parameter int unsigned FILT_50_CYC = 10000,
	parameter int unsigned FILT_75_CYC = 15000,
	parameter int unsigned FILT_100_CYC = 20000
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic ch4HighFlag,
	input wire logic [RANGE_W-1:0] ch4RangeSel,
	input wire logic hvRangeSel,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Bus answer timing
	AST_ANSWER_NEXT: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	AST_ANSWER_ONE: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	AST_NO_UNASKED: assert property (
		avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer without request");
	// Read data shape and holding
	AST_UPPER_ZERO: assert property (
		!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	AST_RDATA_HOLD: assert property (
		$changed(avs_readdata) |-> !avs_waitrequest && avs_read)
		else $error("read data moved outside a read");
	// Range outputs never show code 3 and move only after writes
	AST_RANGE_FOLD: assert property (
		ch4RangeSel != 2'h3)
		else $error("range code three reached the front end");
	AST_RANGE_BY_WRITE: assert property (
		$changed(ch4RangeSel) |-> $past(avs_write) || $past(avs_write, 2))
		else $error("range moved without write");
	AST_HV_BY_WRITE: assert property (
		$changed(hvRangeSel) |-> $past(avs_write) || $past(avs_write, 2))
		else $error("hv range moved without write");

	// Main scenarios reached
	COV_HIGH: cover property ($rose(ch4HighFlag));
	COV_IRQ_ON: cover property ($rose(irq));
	COV_IRQ_OFF: cover property ($fell(irq));
endmodule : sfd_regbank_props

bind sfd_regbank sfd_regbank_props #(
	.FILT_30_CYC(FILT_30_CYC),
	.FILT_50_CYC(FILT_50_CYC),
	.FILT_75_CYC(FILT_75_CYC),
	.FILT_100_CYC(FILT_100_CYC)
) u_props (
	.clock(clock),
	.rst(rst),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.ch4HighFlag(ch4HighFlag),
	.ch4RangeSel(ch4RangeSel),
	.hvRangeSel(hvRangeSel),
	.irq(irq)
);

`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the supply fault detector register bank.
// Assumes the package and the checker file are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module tb;
	import sfd_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] ch4Level = 8'h4B;
	logic [7:0] hvLevel = 8'h00;
	wire [3:0] flags;
	logic [1:0] ch4RangeSel;
	logic hvRangeSel;
	logic irq;
	int err_total = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 50573;
	int dly [8] = '{0, 1000, 2000, 4000, 60, 100, 150, 200};
	logic [5:0] rIdx [13] = '{6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D,
		6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h31};
	logic [7:0] rMsk [13] = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h03,
		8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h01, 8'h0F};
	logic [7:0] rRst [13] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00,
		8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
	logic [7:0] msk [64];
	logic [7:0] mdl [64];

	// Clock and timeout
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total = err_total + 1;
			final_report();
		end
	end

	sfd_regbank #(
		.FILT_30_CYC(60),
		.FILT_50_CYC(100),
		.FILT_75_CYC(150),
		.FILT_100_CYC(200)
	) u_dut (
		.clock(clock),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.ch4Level(ch4Level),
		.hvLevel(hvLevel),
		.ch4HighFlag(flags[0]),
		.ch4LowFlag(flags[1]),
		.hvHighFlag(flags[2]),
		.hvLowFlag(flags[3]),
		.ch4RangeSel(ch4RangeSel),
		.hvRangeSel(hvRangeSel),
		.irq(irq)
	);

	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One bus transfer, held until waitrequest is sampled low
	task xfer(input logic wr, input logic [5:0] idx, input logic [1:0] lo,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge clock);
		avs_address <= {idx, lo};
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk("bus answer", 32'(avs_waitrequest), 32'h0);
	endtask : xfer

	task wr(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, idx, WORD_ALIGN, d, 4'hF, q);
		mdl[idx] = d[7:0] & msk[idx];
	endtask : wr

	task rdc(input string what, input logic [5:0] idx, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, idx, WORD_ALIGN, 32'h0, 4'hF, q);
		chk(what, q, {24'h000000, e});
	endtask : rdc

	task lvl(input logic [7:0] v, input int e);
		ch4Level <= v;
		cyc(8);
		chk("ch4 flags", 32'(flags[1:0]), 32'(e));
	endtask : lvl

	task final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		logic [31:0] q;
		for (int i = 0; i < 64; i++) begin
			msk[i] = 8'h00;
			mdl[i] = 8'h00;
		end
		for (int i = 0; i < 13; i++) begin
			msk[rIdx[i]] = rMsk[i];
			mdl[rIdx[i]] = rRst[i];
		end
		cyc(2);
		rst <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			rdc("reset value", rIdx[i], mdl[rIdx[i]]);
		end
		rdc("reset status", IDX_IRQ_STATUS, 8'h00);
		$display("test reset values done");
		// Random writes, upper bits dropped, refusals
		for (int i = 0; i < 13; i++) wr(rIdx[i], $random(seed));
		xfer(1'b1, IDX_CH4_HIGH_LIMIT, WORD_ALIGN, 32'h0000005A, 4'hE, q);
		wr(6'h3F, 32'h000000A5);
		for (int i = 0; i < 13; i++) begin
			rdc("readback", rIdx[i], mdl[rIdx[i]]);
		end
		rdc("unmapped", 6'h3F, 8'h00);
		xfer(1'b0, IDX_CH4_HIGH_LIMIT, 2'h1, 32'h0, 4'hF, q);
		chk("unaligned", q, 32'h0);
		$display("test register access done");
		// Range selection codes
		for (int r = 0; r < 4; r++) begin
			wr(IDX_CH4_RANGE, 32'(r));
			wr(IDX_HV_RANGE, 32'(r));
			cyc(3);
			chk("ch4 range", 32'(ch4RangeSel),
				(r == 3) ? 32'h2 : 32'(r));
			chk("hv range", 32'(hvRangeSel), 32'(r % 2));
		end
		$display("test range select done");
		// Detector setup, then thresholds with hysteresis
		wr(IDX_CH4_FILT_TYPE, 32'h01);
		wr(IDX_HV_FILT_TYPE, 32'h00);
		wr(IDX_CH4_HIGH_LIMIT, 32'd100);
		wr(IDX_CH4_HIGH_HYST, 32'd10);
		wr(IDX_CH4_LOW_LIMIT, 32'd50);
		wr(IDX_CH4_LOW_HYST, 32'd5);
		wr(IDX_HV_HIGH_LIMIT, 32'd100);
		wr(IDX_HV_HIGH_HYST, 32'h0);
		wr(IDX_HV_LOW_LIMIT, 32'h0);
		wr(IDX_IRQ_MASK, 32'h0F);
		cyc(10);
		xfer(1'b0, IDX_IRQ_STATUS, WORD_ALIGN, 32'h0, 4'hF, q);
		lvl(8'd100, 0);
		lvl(8'd101, 1);
		lvl(8'd95, 1);
		lvl(8'd90, 0);
		lvl(8'd50, 0);
		lvl(8'd49, 2);
		lvl(8'd53, 2);
		lvl(8'd55, 0);
		chk("irq raised", 32'(irq), 32'h1);
		rdc("status", IDX_IRQ_STATUS, 8'h03);
		cyc(3);
		chk("irq cleared", 32'(irq), 32'h0);
		rdc("status cleared", IDX_IRQ_STATUS, 8'h00);
		wr(IDX_IRQ_MASK, 32'h02);
		lvl(8'd101, 1);
		chk("irq masked", 32'(irq), 32'h0);
		rdc("masked status", IDX_IRQ_STATUS, 8'h01);
		lvl(8'd75, 0);
		$display("test thresholds done");
		// Every fault kind
		for (int c = 0; c < 4; c++) begin
			wr(IDX_CH4_FILT_TYPE, 32'(c));
			lvl(8'd150, (c < 2) ? 1 : 0);
			lvl(8'd75, 0);
			lvl(8'd20, (c == 1 || c == 2) ? 2 : 0);
			lvl(8'd75, 0);
		end
		$display("test fault kinds done");
		// Every filter delay, with a short excursion first for each nonzero delay
		xfer(1'b0, IDX_IRQ_STATUS, WORD_ALIGN, 32'h0, 4'hF, q);
		for (int c = 0; c < 8; c++) begin
			wr(IDX_HV_FILT_TYPE, 32'(c * 4));
			if (dly[c] > 0) begin
				hvLevel <= 8'd101 + 8'({$random(seed)} % 100);
				cyc(dly[c] / 2);
				hvLevel <= 8'h00;
				cyc(8);
				rdc("glitch status", IDX_IRQ_STATUS, 8'h00);
			end
			hvLevel <= 8'd200;
			// Output flag rises at the third edge after the delay, read high at the fourth
			cyc(dly[c] + 3);
			chk("hv early", 32'(flags[2]), 32'h0);
			cyc(1);
			chk("hv late", 32'(flags[2]), 32'h1);
			rdc("hv status", IDX_IRQ_STATUS, 8'h04);
			hvLevel <= 8'h00;
			cyc(8);
		end
		$display("test filter delays done");
		// High-voltage low flag, live flag register and its clearing
		wr(IDX_HV_LOW_LIMIT, 32'd10);
		wr(IDX_HV_FILT_TYPE, 32'(KIND_LOW));
		cyc(8);
		chk("hv low", 32'(flags[3]), 32'h1);
		rdc("live flags", IDX_LIVE_FLAGS, 8'h08);
		rdc("hv low status", IDX_IRQ_STATUS, 8'h08);
		hvLevel <= 8'd50;
		cyc(8);
		chk("hv low clear", 32'(flags[3]), 32'h0);
		$display("test low flag done");
		final_report();
	end
endmodule : tb

`default_nettype wire
